/* verilog/cpg_pkg.sv */
package cpg_pkg;

   // ----------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_CELL_CNT_EN = 7'h0A;
   localparam logic [6:0] ADDR_ADAPT_CNT_EN = 7'h0B;
   localparam logic [6:0] ADDR_PATTERN_HIGH = 7'h0C;
   localparam logic [6:0] ADDR_PATTERN_LOW = 7'h0D;
   localparam logic [6:0] ADDR_DELIN_CTRL = 7'h0E;
   localparam logic [6:0] ADDR_RX_EMPTY = 7'h0F;
   localparam logic [6:0] ADDR_TX_EMPTY = 7'h10;
   localparam logic [6:0] ADDR_LOOP_CTRL = 7'h11;
   localparam logic [6:0] ADDR_FILL = 7'h12;
   localparam logic [6:0] ADDR_IRQ_MASK = 7'h13;
   localparam logic [6:0] ADDR_TIMER_EN = 7'h14;
   localparam logic [6:0] ADDR_DELIN_STATE = 7'h15;
   localparam logic [6:0] ADDR_REVISION = 7'h16;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_CELL_CNT_EN = 16'h0000;
   localparam logic [15:0] RST_ADAPT_CNT_EN = 16'h0000;
   localparam logic [15:0] RST_PATTERN_HIGH = 16'h0000;
   localparam logic [15:0] RST_PATTERN_LOW = 16'h0000;
   localparam logic [15:0] RST_DELIN_CTRL = 16'h7655;
   localparam logic [15:0] RST_RX_EMPTY = 16'h0101;
   localparam logic [15:0] RST_TX_EMPTY = 16'h016A;
   localparam logic [15:0] RST_LOOP_CTRL = 16'h0000;
   localparam logic [15:0] RST_FILL = 16'h0000;
   localparam logic [15:0] RST_IRQ_MASK = 16'hFFFF;
   localparam logic [15:0] RST_TIMER_EN = 16'h0000;
   // arbitrary value, not a real part revision
   localparam logic [5:0] REVISION_CODE = 6'h2A;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CELL_EN_W = 6;
   localparam int ALPHA_LSB = 12;
   localparam int DELTA_LSB = 8;
   localparam int COSET_LSB = 0;
   localparam int HDR_HI_LSB = 12;
   localparam int HDR_LO_LSB = 8;
   localparam int IGN_LSB = 0;
   localparam int TX_PL_LSB = 0;
   localparam int SER_LOOP_BIT = 8;
   localparam int UP_LOOP_BIT = 7;
   localparam int DN_LOOP_BIT = 6;
   localparam int VCI_FLT_BIT = 5;
   localparam int VCI_VAL_LSB = 0;
   localparam int BUS_STYLE_BIT = 8;
   localparam int CANCEL_BIT = 7;
   localparam int LINE_STD_BIT = 6;
   localparam int NUM_PORTS = 8;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CPG_HUNT,
      CPG_PRESYNC,
      CPG_SYNC
   } cpg_delin_t;

   typedef struct packed {
      cpg_delin_t state;
      logic [3:0] count;
   } cpg_port_t;

   typedef struct packed {
      logic [15:0] cell_cnt_en;
      logic [15:0] adapt_cnt_en;
      logic [15:0] pattern_high;
      logic [15:0] pattern_low;
      logic [15:0] delin_ctrl;
      logic [15:0] rx_empty;
      logic [15:0] tx_empty;
      logic [15:0] loop_ctrl;
      logic [15:0] fill;
      logic [15:0] irq_mask;
      logic [15:0] timer_en;
   } cpg_regs_t;

   typedef struct packed {
      logic [7:0] port_is_cell;
      logic [7:0] hec_valid;
      logic [7:0] hec_ok;
   } cpg_delin_in_t;

endpackage

/* verilog/cpg_regs.sv */
`timescale 1ns/1ps
module cpg_regs (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_resetn,
   // host register port
   input wire logic i_host_wr,
   input wire logic i_host_rd,
   input wire logic [6:0] i_host_addr,
   input wire logic [15:0] i_host_wdata,
   output logic [15:0] o_host_rdata,
   output logic o_host_rdack,
   // strap pins
   input wire logic i_bus_style_pin,
   input wire logic i_canceller_pin,
   input wire logic i_line_standard_pin,
   // port configuration and hec results
   input wire cpg_pkg::cpg_delin_in_t i_delin,
   input wire logic [7:0] i_hec_calc,
   // datapath requests
   input wire logic [31:0] i_rx_header,
   input wire logic [1:0] i_emg_sel,
   input wire logic [15:0] i_irq_status_one,
   input wire logic [4:0] i_ulp_vci,
   input wire logic i_ulp_port_cell,
   // control outputs
   output logic [7:0] o_cell_oam_en,
   output logic [15:0] o_adapt_oam_en,
   output logic [7:0] o_hec_coset_out,
   output logic o_rx_idle_match,
   output logic [31:0] o_tx_idle_header,
   output logic [7:0] o_tx_idle_payload,
   output logic o_serial_loop_fwd,
   output logic o_up_loop_take,
   output logic o_up_loop_fwd,
   output logic o_dn_loop_fwd,
   output logic [7:0] o_fill_octet,
   output logic [7:0] o_emg_pattern,
   output logic [15:0] o_irq_status_masked,
   output logic o_second_timer_group_on,
   output logic [15:0] o_port_delineation_state
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] style_sync;
      logic [1:0] cancel_sync;
      logic [1:0] line_sync;
      cpg_pkg::cpg_regs_t regs;
      cpg_pkg::cpg_port_t [7:0] ports;
      logic [15:0] rdata;
      logic rdack;
      logic [7:0] cell_oam;
      logic [15:0] adapt_oam;
      logic [7:0] coset_out;
      logic rx_match;
      logic [31:0] tx_hdr;
      logic [7:0] tx_pl;
      logic ser_fwd;
      logic up_take;
      logic up_fwd;
      logic dn_fwd;
      logic [7:0] fill;
      logic [7:0] emg;
      logic [15:0] irq_masked;
      logic timer2;
      logic [15:0] delin_rd;
   } cpg_state_t;

   cpg_state_t state_ff;
   cpg_state_t nxt_state;
   logic rst_n;

   assign rst_n = state_ff.rst_sync[1];

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] pack_delin(input cpg_pkg::cpg_port_t [7:0] p);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < cpg_pkg::NUM_PORTS; i++) begin
         r[2*i +: 2] = p[i].state;
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [3:0] alpha;
      logic [3:0] delta;
      logic [3:0] hi_val;
      logic [3:0] lo_val;
      logic [7:0] ign;
      logic [31:0] exp_hdr;
      logic [31:0] cmp_mask;
      logic [3:0] cnt1;
      alpha = 4'h0;
      delta = 4'h0;
      hi_val = 4'h0;
      lo_val = 4'h0;
      ign = 8'h00;
      exp_hdr = 32'h0000_0000;
      cmp_mask = 32'h0000_0000;
      cnt1 = 4'h0;
      nxt_state = state_ff;
      nxt_state.rst_sync = {state_ff.rst_sync[0], 1'b1};
      nxt_state.style_sync = {state_ff.style_sync[0], i_bus_style_pin};
      nxt_state.cancel_sync = {state_ff.cancel_sync[0], i_canceller_pin};
      nxt_state.line_sync = {state_ff.line_sync[0], i_line_standard_pin};
      // register writes
      if (i_host_wr) begin
         case (i_host_addr)
            cpg_pkg::ADDR_CELL_CNT_EN: begin
               nxt_state.regs.cell_cnt_en = {10'h000, i_host_wdata[5:0]};
            end
            cpg_pkg::ADDR_ADAPT_CNT_EN: begin
               nxt_state.regs.adapt_cnt_en = i_host_wdata;
            end
            cpg_pkg::ADDR_PATTERN_HIGH: begin
               nxt_state.regs.pattern_high = i_host_wdata;
            end
            cpg_pkg::ADDR_PATTERN_LOW: begin
               nxt_state.regs.pattern_low = i_host_wdata;
            end
            cpg_pkg::ADDR_DELIN_CTRL: begin
               nxt_state.regs.delin_ctrl = i_host_wdata;
            end
            cpg_pkg::ADDR_RX_EMPTY: begin
               nxt_state.regs.rx_empty = i_host_wdata;
            end
            cpg_pkg::ADDR_TX_EMPTY: begin
               nxt_state.regs.tx_empty = i_host_wdata;
            end
            cpg_pkg::ADDR_LOOP_CTRL: begin
               nxt_state.regs.loop_ctrl = {7'h00, i_host_wdata[8:0]};
            end
            cpg_pkg::ADDR_FILL: begin
               nxt_state.regs.fill = {8'h00, i_host_wdata[7:0]};
            end
            cpg_pkg::ADDR_IRQ_MASK: begin
               nxt_state.regs.irq_mask = i_host_wdata;
            end
            cpg_pkg::ADDR_TIMER_EN: begin
               nxt_state.regs.timer_en = {15'h0000, i_host_wdata[0]};
            end
            default: begin
            end
         endcase
      end
      // register reads, answer one cycle later
      nxt_state.rdack = i_host_rd;
      nxt_state.rdata = 16'h0000;
      if (i_host_rd) begin
         case (i_host_addr)
            cpg_pkg::ADDR_CELL_CNT_EN: nxt_state.rdata = state_ff.regs.cell_cnt_en;
            cpg_pkg::ADDR_ADAPT_CNT_EN: nxt_state.rdata = state_ff.regs.adapt_cnt_en;
            cpg_pkg::ADDR_PATTERN_HIGH: nxt_state.rdata = state_ff.regs.pattern_high;
            cpg_pkg::ADDR_PATTERN_LOW: nxt_state.rdata = state_ff.regs.pattern_low;
            cpg_pkg::ADDR_DELIN_CTRL: nxt_state.rdata = state_ff.regs.delin_ctrl;
            cpg_pkg::ADDR_RX_EMPTY: nxt_state.rdata = state_ff.regs.rx_empty;
            cpg_pkg::ADDR_TX_EMPTY: nxt_state.rdata = state_ff.regs.tx_empty;
            cpg_pkg::ADDR_LOOP_CTRL: nxt_state.rdata = state_ff.regs.loop_ctrl;
            cpg_pkg::ADDR_FILL: nxt_state.rdata = state_ff.regs.fill;
            cpg_pkg::ADDR_IRQ_MASK: nxt_state.rdata = state_ff.regs.irq_mask;
            cpg_pkg::ADDR_TIMER_EN: nxt_state.rdata = state_ff.regs.timer_en;
            cpg_pkg::ADDR_DELIN_STATE: nxt_state.rdata = pack_delin(state_ff.ports);
            cpg_pkg::ADDR_REVISION: begin
               nxt_state.rdata[cpg_pkg::BUS_STYLE_BIT] = state_ff.style_sync[1];
               nxt_state.rdata[cpg_pkg::CANCEL_BIT] = state_ff.cancel_sync[1];
               nxt_state.rdata[cpg_pkg::LINE_STD_BIT] = state_ff.line_sync[1];
               nxt_state.rdata[5:0] = cpg_pkg::REVISION_CODE;
            end
            default: nxt_state.rdata = 16'h0000;
         endcase
      end
      // ----------------------------------------------------------------
      // delineation machines
      // ----------------------------------------------------------------
      alpha = state_ff.regs.delin_ctrl[cpg_pkg::ALPHA_LSB +: 4];
      delta = state_ff.regs.delin_ctrl[cpg_pkg::DELTA_LSB +: 4];
      for (int i = 0; i < cpg_pkg::NUM_PORTS; i++) begin
         cnt1 = state_ff.ports[i].count + 4'h1;
         if (!i_delin.port_is_cell[i]) begin
            nxt_state.ports[i].state = cpg_pkg::CPG_HUNT;
            nxt_state.ports[i].count = 4'h0;
         end else if (i_delin.hec_valid[i]) begin
            case (state_ff.ports[i].state)
               cpg_pkg::CPG_HUNT: begin
                  if (i_delin.hec_ok[i]) begin
                     nxt_state.ports[i].state = cpg_pkg::CPG_PRESYNC;
                     nxt_state.ports[i].count = 4'h1;
                  end
               end
               cpg_pkg::CPG_PRESYNC: begin
                  if (!i_delin.hec_ok[i]) begin
                     nxt_state.ports[i].state = cpg_pkg::CPG_HUNT;
                     nxt_state.ports[i].count = 4'h0;
                  end else if (cnt1 >= delta) begin
                     nxt_state.ports[i].state = cpg_pkg::CPG_SYNC;
                     nxt_state.ports[i].count = 4'h0;
                  end else begin
                     nxt_state.ports[i].count = cnt1;
                  end
               end
               cpg_pkg::CPG_SYNC: begin
                  if (i_delin.hec_ok[i]) begin
                     nxt_state.ports[i].count = 4'h0;
                  end else if (cnt1 >= alpha) begin
                     nxt_state.ports[i].state = cpg_pkg::CPG_HUNT;
                     nxt_state.ports[i].count = 4'h0;
                  end else begin
                     nxt_state.ports[i].count = cnt1;
                  end
               end
               default: begin
                  nxt_state.ports[i].state = cpg_pkg::CPG_HUNT;
                  nxt_state.ports[i].count = 4'h0;
               end
            endcase
         end
      end
      nxt_state.delin_rd = pack_delin(nxt_state.ports);
      // ----------------------------------------------------------------
      // oam counter enables
      // ----------------------------------------------------------------
      for (int i = 0; i < cpg_pkg::NUM_PORTS; i++) begin
         if (i < cpg_pkg::CELL_EN_W) begin
            nxt_state.cell_oam[i] = state_ff.regs.cell_cnt_en[i]
                                    & i_delin.port_is_cell[i];
         end else begin
            nxt_state.cell_oam[i] = 1'b0;
         end
      end
      for (int k = 0; k < 16; k++) begin
         nxt_state.adapt_oam[k] = state_ff.regs.adapt_cnt_en[k]
                                  & ~i_delin.port_is_cell[k % 8];
      end
      // ----------------------------------------------------------------
      // hec coset and idle cells
      // ----------------------------------------------------------------
      nxt_state.coset_out = i_hec_calc
                            ^ state_ff.regs.delin_ctrl[cpg_pkg::COSET_LSB +: 8];
      hi_val = state_ff.regs.rx_empty[cpg_pkg::HDR_HI_LSB +: 4];
      lo_val = state_ff.regs.rx_empty[cpg_pkg::HDR_LO_LSB +: 4];
      ign = state_ff.regs.rx_empty[cpg_pkg::IGN_LSB +: 8];
      exp_hdr = {hi_val, 24'h000000, lo_val};
      cmp_mask = ~{ign[7:4], 24'h000000, ign[3:0]};
      nxt_state.rx_match = ((i_rx_header ^ exp_hdr) & cmp_mask) == 32'h0000_0000;
      nxt_state.tx_hdr = {state_ff.regs.tx_empty[cpg_pkg::HDR_HI_LSB +: 4], 24'h000000,
                          state_ff.regs.tx_empty[cpg_pkg::HDR_LO_LSB +: 4]};
      nxt_state.tx_pl = state_ff.regs.tx_empty[cpg_pkg::TX_PL_LSB +: 8];
      // ----------------------------------------------------------------
      // loops
      // ----------------------------------------------------------------
      nxt_state.ser_fwd = state_ff.regs.loop_ctrl[cpg_pkg::SER_LOOP_BIT];
      nxt_state.dn_fwd = state_ff.regs.loop_ctrl[cpg_pkg::DN_LOOP_BIT];
      nxt_state.up_fwd = state_ff.regs.loop_ctrl[cpg_pkg::UP_LOOP_BIT]
                         & ~i_ulp_port_cell;
      if (i_ulp_port_cell) begin
         nxt_state.up_take = 1'b1;
      end else if (state_ff.regs.loop_ctrl[cpg_pkg::VCI_FLT_BIT]) begin
         nxt_state.up_take = i_ulp_vci
                             == state_ff.regs.loop_ctrl[cpg_pkg::VCI_VAL_LSB +: 5];
      end else begin
         nxt_state.up_take = 1'b1;
      end
      // ----------------------------------------------------------------
      // fill, patterns, mask, timer
      // ----------------------------------------------------------------
      nxt_state.fill = state_ff.regs.fill[7:0];
      case (i_emg_sel)
         2'b00: nxt_state.emg = state_ff.regs.pattern_low[7:0];
         2'b01: nxt_state.emg = state_ff.regs.pattern_low[15:8];
         2'b10: nxt_state.emg = state_ff.regs.pattern_high[7:0];
         default: nxt_state.emg = state_ff.regs.pattern_high[15:8];
      endcase
      nxt_state.irq_masked = i_irq_status_one & ~state_ff.regs.irq_mask;
      nxt_state.timer2 = state_ff.regs.timer_en[0];
      if (!rst_n) begin
         nxt_state.regs = '{
            cell_cnt_en: cpg_pkg::RST_CELL_CNT_EN,
            adapt_cnt_en: cpg_pkg::RST_ADAPT_CNT_EN,
            pattern_high: cpg_pkg::RST_PATTERN_HIGH,
            pattern_low: cpg_pkg::RST_PATTERN_LOW,
            delin_ctrl: cpg_pkg::RST_DELIN_CTRL,
            rx_empty: cpg_pkg::RST_RX_EMPTY,
            tx_empty: cpg_pkg::RST_TX_EMPTY,
            loop_ctrl: cpg_pkg::RST_LOOP_CTRL,
            fill: cpg_pkg::RST_FILL,
            irq_mask: cpg_pkg::RST_IRQ_MASK,
            timer_en: cpg_pkg::RST_TIMER_EN
         };
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_ff <= '0;
         state_ff.regs.delin_ctrl <= cpg_pkg::RST_DELIN_CTRL;
         state_ff.regs.rx_empty <= cpg_pkg::RST_RX_EMPTY;
         state_ff.regs.tx_empty <= cpg_pkg::RST_TX_EMPTY;
         state_ff.regs.irq_mask <= cpg_pkg::RST_IRQ_MASK;
         state_ff.tx_hdr <= 32'h0000_0001;
         state_ff.tx_pl <= 8'h6A;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_host_rdata = state_ff.rdata;
   assign o_host_rdack = state_ff.rdack;
   assign o_cell_oam_en = state_ff.cell_oam;
   assign o_adapt_oam_en = state_ff.adapt_oam;
   assign o_hec_coset_out = state_ff.coset_out;
   assign o_rx_idle_match = state_ff.rx_match;
   assign o_tx_idle_header = state_ff.tx_hdr;
   assign o_tx_idle_payload = state_ff.tx_pl;
   assign o_serial_loop_fwd = state_ff.ser_fwd;
   assign o_up_loop_take = state_ff.up_take;
   assign o_up_loop_fwd = state_ff.up_fwd;
   assign o_dn_loop_fwd = state_ff.dn_fwd;
   assign o_fill_octet = state_ff.fill;
   assign o_emg_pattern = state_ff.emg;
   assign o_irq_status_masked = state_ff.irq_masked;
   assign o_second_timer_group_on = state_ff.timer2;
   assign o_port_delineation_state = state_ff.delin_rd;

endmodule

/* testbench/cpg_regs_properties.sv */
`timescale 1ns/1ps
module cpg_regs_check (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_host_wr,
   input wire logic i_host_rd,
   input wire logic [6:0] i_host_addr,
   input wire logic [15:0] i_host_wdata,
   input wire logic [15:0] o_host_rdata,
   input wire logic o_host_rdack,
   input wire logic [7:0] i_hec_calc,
   input wire logic [7:0] o_hec_coset_out,
   input wire logic [15:0] i_irq_status_one,
   input wire logic [15:0] o_irq_status_masked,
   input wire logic [31:0] i_rx_header,
   input wire logic o_rx_idle_match,
   input wire logic [31:0] o_tx_idle_header,
   input wire logic i_ulp_port_cell,
   input wire logic o_up_loop_fwd,
   input wire logic [15:0] o_port_delineation_state
);
   // ----
   // shadows
   // ----
   logic [1:0] ok_ff;
   logic [15:0] dc_ff;
   logic [15:0] mk_ff;
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ok_ff <= 2'h0;
         dc_ff <= 16'h7655;
         mk_ff <= 16'hFFFF;
      end else begin
         if (ok_ff != 2'h3) ok_ff <= ok_ff + 2'h1;
         if (i_host_wr && i_host_addr == 7'h0E) dc_ff <= i_host_wdata;
         if (i_host_wr && i_host_addr == 7'h13) mk_ff <= i_host_wdata;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (ok_ff != 2'h3);
   AST_COSET: assert property (o_hec_coset_out == ($past(i_hec_calc) ^ $past(dc_ff[7:0])))
      else $error("coset output wrong");
   AST_MASK: assert property (o_irq_status_masked == $past(i_irq_status_one & ~mk_ff))
      else $error("masked status wrong");
   AST_NO11: assert property (!(|(o_port_delineation_state & (o_port_delineation_state >> 1) & 16'h5555)))
      else $error("state 11 seen");
   AST_RD_DC: assert property ($past(i_host_rd && i_host_addr == 7'h0E) |-> o_host_rdack && o_host_rdata == $past(dc_ff))
      else $error("delineation control read wrong");
   AST_RD_MK: assert property ($past(i_host_rd && i_host_addr == 7'h13) |-> o_host_rdack && o_host_rdata == $past(mk_ff))
      else $error("mask read wrong");
   AST_REV: assert property ($past(i_host_rd && i_host_addr == 7'h16) |-> o_host_rdata[5:0] == cpg_pkg::REVISION_CODE && o_host_rdata[15:9] == 7'h00)
      else $error("revision read wrong");
   AST_TXZ: assert property ((o_tx_idle_header & 32'h0FFFFFF0) == 32'h0)
      else $error("tx header bits not zero");
   AST_RXZ: assert property ($past(|(i_rx_header & 32'h0FFFFFF0)) |-> !o_rx_idle_match)
      else $error("idle match with nonzero bits");
   AST_UFWD: assert property ($past(i_ulp_port_cell) |-> !o_up_loop_fwd)
      else $error("forward on cell port");
endmodule
bind cpg_regs cpg_regs_check i_cpg_regs_check (.i_core_clk, .i_resetn, .i_host_wr, .i_host_rd,
   .i_host_addr, .i_host_wdata, .o_host_rdata, .o_host_rdack, .i_hec_calc, .o_hec_coset_out,
   .i_irq_status_one, .o_irq_status_masked, .i_rx_header, .o_rx_idle_match, .o_tx_idle_header,
   .i_ulp_port_cell, .o_up_loop_fwd, .o_port_delineation_state);

/* testbench/cpg_host.sv */
`timescale 1ns/1ps
module cpg_host (
   // clock
   input wire logic i_core_clk,
   // host register port
   output logic o_wr,
   output logic o_rd,
   output logic [6:0] o_addr,
   output logic [15:0] o_wdata,
   input wire logic [15:0] i_rdata,
   input wire logic i_rdack
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 7'h00;
      o_wdata = 16'h0000;
   end
   task automatic wr(input logic [6:0] a, input logic [15:0] v);
      @(posedge i_core_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= v;
      @(posedge i_core_clk);
      o_wr <= 1'b0;
      o_wdata <= ~v;
   endtask
   task automatic rd(input logic [6:0] a, output logic [15:0] v, output logic k);
      @(posedge i_core_clk);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_core_clk);
      o_rd <= 1'b0;
      @(posedge i_core_clk);
      v = i_rdata;
      k = i_rdack;
   endtask
endmodule

/* testbench/cell_port_global_control_regs_bench.sv */
`timescale 1ns/1ps
module cell_port_global_control_regs_bench;
   logic i_core_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic wr, rd, rk, ak, idle, sf, tk, uf, df, tm, pc;
   logic [6:0] ad;
   logic [15:0] wd, rdt, d, ms, ds, ao, irq;
   logic [7:0] hc, co, fo, ep, py, ce;
   logic [31:0] hd, th, e;
   logic [1:0] sel;
   logic [4:0] vci;
   cpg_pkg::cpg_delin_in_t dl;
   int n_fail = 0;
   int checks_done = 0;
   logic [15:0] rv [11] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h7655, 16'h0101,
      16'h016A, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000};
   logic [15:0] mk [11] = '{16'h003F, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'h01FF, 16'h00FF, 16'hFFFF, 16'h0001};
   logic [1:0] st [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
   always #50 i_core_clk = ~i_core_clk;
   cpg_host i_cpg_host (.i_core_clk(i_core_clk), .o_wr(wr), .o_rd(rd), .o_addr(ad),
      .o_wdata(wd), .i_rdata(rdt), .i_rdack(rk));
   cpg_regs i_cpg_regs (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_host_wr(wr),
      .i_host_rd(rd), .i_host_addr(ad), .i_host_wdata(wd), .o_host_rdata(rdt),
      .o_host_rdack(rk), .i_bus_style_pin(1'b1), .i_canceller_pin(1'b0),
      .i_line_standard_pin(1'b1), .i_delin(dl), .i_hec_calc(hc), .i_rx_header(hd),
      .i_emg_sel(sel), .i_irq_status_one(irq), .i_ulp_vci(vci), .i_ulp_port_cell(pc),
      .o_cell_oam_en(ce), .o_adapt_oam_en(ao), .o_hec_coset_out(co), .o_rx_idle_match(idle),
      .o_tx_idle_header(th), .o_tx_idle_payload(py), .o_serial_loop_fwd(sf),
      .o_up_loop_take(tk), .o_up_loop_fwd(uf), .o_dn_loop_fwd(df), .o_fill_octet(fo),
      .o_emg_pattern(ep), .o_irq_status_masked(ms), .o_second_timer_group_on(tm),
      .o_port_delineation_state(ds));
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", s, x, g);
      end
   endtask
   task automatic stl;
      repeat (2) @(posedge i_core_clk);
      #1;
   endtask
   task automatic rchk(input logic [6:0] a, input logic [15:0] x);
      i_cpg_host.rd(a, d, ak);
      chk("rdack", 32'h1, {31'h0, ak});
      chk("rdata", {16'h0, x}, {16'h0, d});
   endtask
   task automatic hchk(input logic [31:0] h, input logic x);
      @(posedge i_core_clk);
      hd <= h;
      stl;
      chk("idle match", {31'h0, x}, {31'h0, idle});
   endtask
   task automatic uchk(input logic [4:0] v, input logic c, input logic x);
      @(posedge i_core_clk);
      vci <= v;
      pc <= c;
      stl;
      chk("loop take", {31'h0, x}, {31'h0, tk});
   endtask
   task automatic stop_test;
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #500000;
      n_fail++;
      stop_test;
   end
   initial begin
      dl = '0;
      dl.port_is_cell = 8'h0F;
      hc = 8'h00;
      hd = 32'h0;
      sel = 2'h0;
      irq = 16'h0000;
      vci = 5'h00;
      pc = 1'b0;
      repeat (20) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      for (int i = 0; i < 11; i++) begin
         rchk(7'h0A + 7'(i), rv[i]);
         i_cpg_host.wr(7'h0A + 7'(i), 16'hFFFF);
         rchk(7'h0A + 7'(i), mk[i]);
         i_cpg_host.wr(7'h0A + 7'(i), rv[i]);
      end
      i_cpg_host.wr(7'h15, 16'hFFFF);
      rchk(7'h15, 16'h0000);
      i_cpg_host.wr(7'h16, 16'h0000);
      rchk(7'h16, 16'h016A);
      i_cpg_host.wr(7'h7F, 16'hFFFF);
      rchk(7'h7F, 16'h0000);
      i_cpg_host.wr(7'h0A, 16'h003F);
      i_cpg_host.wr(7'h0B, 16'hFFFF);
      stl;
      chk("cell oam", 32'h0F, {24'h0, ce});
      chk("adapt oam", 32'hF0F0, {16'h0, ao});
      i_cpg_host.wr(7'h0C, 16'hD4C3);
      i_cpg_host.wr(7'h0D, 16'hB2A1);
      for (int i = 0; i < 4; i++) begin
         @(posedge i_core_clk);
         sel <= 2'(i);
         stl;
         e = 32'hD4C3B2A1 >> (8 * i);
         chk("pattern", {24'h0, e[7:0]}, {24'h0, ep});
      end
      i_cpg_host.wr(7'h10, 16'hB73C);
      i_cpg_host.wr(7'h12, 16'h00A5);
      i_cpg_host.wr(7'h14, 16'h0001);
      stl;
      chk("tx header", 32'hB0000007, th);
      chk("tx payload", 32'h3C, {24'h0, py});
      chk("fill", 32'hA5, {24'h0, fo});
      chk("timer", 32'h1, {31'h0, tm});
      i_cpg_host.wr(7'h0E, 16'h2399);
      i_cpg_host.wr(7'h13, 16'h00FF);
      @(posedge i_core_clk);
      hc <= 8'h0F;
      irq <= 16'h5AA5;
      stl;
      chk("coset", 32'h96, {24'h0, co});
      chk("irq masked", 32'h5A00, {16'h0, ms});
      for (int i = 0; i < 5; i++) begin
         @(posedge i_core_clk);
         dl.hec_valid <= 8'h01;
         dl.hec_ok <= {7'h0, i < 3};
         @(posedge i_core_clk);
         dl.hec_valid <= 8'h00;
         stl;
         chk("state", {30'h0, st[i]}, {16'h0, ds});
      end
      hchk(32'h00000001, 1'b1);
      hchk(32'h00000003, 1'b0);
      i_cpg_host.wr(7'h0F, 16'h0103);
      hchk(32'h00000003, 1'b1);
      hchk(32'h00010003, 1'b0);
      i_cpg_host.wr(7'h11, 16'h01E5);
      uchk(5'h05, 1'b0, 1'b1);
      chk("serial fwd", 32'h1, {31'h0, sf});
      chk("down fwd", 32'h1, {31'h0, df});
      chk("up fwd", 32'h1, {31'h0, uf});
      uchk(5'h06, 1'b0, 1'b0);
      uchk(5'h06, 1'b1, 1'b1);
      chk("up fwd cell", 32'h0, {31'h0, uf});
      stop_test;
   end
endmodule
